// ===== proc_pkg.sv
// constants, register map and state codes of the parallel result output block
// assumes a 100 MHz clock and an APB master with 32-bit data
package proc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int RES_W  = 16;
  localparam int TMR_W  = 32;

  localparam logic [ADDR_W-1:0] OFF_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_PERIOD  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_DELAY   = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_WIDTH   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_TMO     = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_ORTIME  = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_RESULT  = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_STATUS  = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ST  = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLR = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_IRQ_EN  = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_PHASE   = 8'h2C;

  localparam int CTRL_POL_PASS = 0;
  localparam int CTRL_HS       = 1;
  localparam int CTRL_ONESHOT  = 2;
  localparam int CTRL_ENPT_LSB = 3;
  localparam int CTRL_INV      = 5;
  localparam int CTRL_W        = 6;
  localparam logic [1:0] ENPT_IMAGE = 2'h0;
  localparam logic [1:0] ENPT_MEAS  = 2'h1;
  localparam logic [1:0] ENPT_DISP  = 2'h2;

  localparam int RES_OVR_BIT = 16;

  localparam int PH_START = 0;
  localparam int PH_IMAGE = 1;
  localparam int PH_MEAS  = 2;
  localparam int PH_DISP  = 3;

  localparam int IRQ_SENT = 0;
  localparam int IRQ_TMO  = 1;
  localparam int IRQ_ACK  = 2;
  localparam int IRQ_W    = 3;

  localparam logic [CTRL_W-1:0] CTRL_RST   = 6'h08;
  localparam logic [TMR_W-1:0]  PERIOD_RST = 32'h0000_0064;
  localparam logic [TMR_W-1:0]  DELAY_RST  = 32'h0000_000A;
  localparam logic [TMR_W-1:0]  WIDTH_RST  = 32'h0000_0032;
  localparam logic [TMR_W-1:0]  TMO_RST    = 32'h0000_2710;
  localparam logic [7:0]        ORTIME_RST = 8'h00;

  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_US       = 100;
  localparam int TICK_CYCLES   = (TICK_US * 1000) / CLK_PERIOD_NS;
  localparam int TICKS_PER_MS  = 1000 / TICK_US;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_DELAY  = 5'b00010,
    ST_STROBE = 5'b00100,
    ST_ACK    = 5'b01000,
    ST_GAP    = 5'b10000
  } proc_state_t;
endpackage

// ===== proc_timer.sv
// loadable down counter stepped by a shared time tick
// assumes load and tick are synchronous one-cycle pulses
module proc_timer #(
  parameter int W = 32
) (
  input  wire logic         clock_in,
  input  wire logic         rst_n_in,
  input  wire logic         load_in,
  input  wire logic [W-1:0] value_in,
  input  wire logic         tick_in,
  output logic              done_out
);
  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;

  always_comb begin
    count_nxt = count_r;
    if (load_in) begin
      count_nxt = value_in;
    end else if (tick_in && (count_r != '0)) begin
      count_nxt = count_r - W'(1);
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  // tick phase makes each interval up to one tick short
  assign done_out = (count_r == '0);
endmodule

// ===== proc_top.sv
// parallel result output controller with APB registers and one interrupt line
// assumes apb master, receiver ack and inputs all synchronous to clock_in
//
// Chosen here: the register addresses and the APB register port.
module proc_top #(
  parameter int TICK_CYCLES = proc_pkg::TICK_CYCLES
) (
  input  wire logic                          clock_in,
  input  wire logic                          rst_n_in,
  input  wire logic                          psel_in,
  input  wire logic                          penable_in,
  input  wire logic                          pwrite_in,
  input  wire logic [proc_pkg::ADDR_W-1:0]   paddr_in,
  input  wire logic [proc_pkg::DATA_W-1:0]   pwdata_in,
  output logic      [proc_pkg::DATA_W-1:0]   prdata_out,
  output logic                               pready_out,
  output logic                               pslverr_out,
  input  wire logic                          ack_in,
  output logic      [proc_pkg::RES_W-1:0]    result_data_lines_out,
  output logic                               strobe_out,
  output logic                               fail_judgment_out,
  output logic                               enable_out,
  output logic                               timeout_err_out,
  output logic                               irq_out
);
  import proc_pkg::*;

  logic [CTRL_W-1:0] ctrl_r,    ctrl_nxt;
  logic [TMR_W-1:0]  period_r,  period_nxt;
  logic [TMR_W-1:0]  delay_r,   delay_nxt;
  logic [TMR_W-1:0]  width_r,   width_nxt;
  logic [TMR_W-1:0]  tmo_r,     tmo_nxt;
  logic [7:0]        ortime_r,  ortime_nxt;
  logic [RES_W:0]    pend_r,    pend_nxt;
  logic              pend_v_r,  pend_v_nxt;
  logic [IRQ_W-1:0]  irq_st_r,  irq_st_nxt;
  logic [IRQ_W-1:0]  irq_en_r,  irq_en_nxt;
  logic [DATA_W-1:0] prdata_r,  prdata_nxt;
  logic              pready_r,  pready_nxt;
  logic              pslverr_r, pslverr_nxt;
  logic              ready_r,   ready_nxt;
  logic              enable_r,  enable_nxt;
  logic              irq_r,     irq_nxt;
  logic [31:0]       tick_cnt_r, tick_cnt_nxt;
  logic              tick_r,    tick_nxt;

  proc_state_t       state_r,   state_nxt;
  logic [RES_W-1:0]  data_r,    data_nxt;
  logic              strobe_r,  strobe_nxt;
  logic              or_r,      or_nxt;

  logic              phase_load, period_load, or_load;
  logic [TMR_W-1:0]  phase_val;
  logic [TMR_W-1:0]  or_val;
  logic              phase_done, period_done, or_done;
  logic              acc, wr, mapped;
  logic [IRQ_W-1:0]  ev;
  logic              pol_pass, active;

  assign acc = psel_in && penable_in && pready_r;
  assign wr  = acc && pwrite_in;
  assign pol_pass = ctrl_r[CTRL_POL_PASS];

  always_comb begin
    unique case (paddr_in)
      OFF_CTRL, OFF_PERIOD, OFF_DELAY, OFF_WIDTH, OFF_TMO, OFF_ORTIME,
      OFF_RESULT, OFF_STATUS, OFF_IRQ_ST, OFF_IRQ_CLR, OFF_IRQ_EN,
      OFF_PHASE: mapped = 1'b1;
      default:   mapped = 1'b0;
    endcase
  end

  // one wait state; read data and error are registered with pready
  always_comb begin
    pready_nxt  = psel_in && penable_in && !pready_r;
    pslverr_nxt = pready_nxt && !mapped;
    prdata_nxt  = '0;
    if (pready_nxt && !pwrite_in) begin
      unique case (paddr_in)
        OFF_CTRL:   prdata_nxt = DATA_W'(ctrl_r);
        OFF_PERIOD: prdata_nxt = period_r;
        OFF_DELAY:  prdata_nxt = delay_r;
        OFF_WIDTH:  prdata_nxt = width_r;
        OFF_TMO:    prdata_nxt = tmo_r;
        OFF_ORTIME: prdata_nxt = DATA_W'(ortime_r);
        OFF_RESULT: prdata_nxt = DATA_W'(pend_r);
        OFF_STATUS: prdata_nxt = DATA_W'({pend_v_r, ready_r, or_r, strobe_r, state_r});
        OFF_IRQ_ST: prdata_nxt = DATA_W'(irq_st_r);
        OFF_IRQ_EN: prdata_nxt = DATA_W'(irq_en_r);
        default:    prdata_nxt = '0;
      endcase
    end
  end

  always_comb begin
    ctrl_nxt   = ctrl_r;
    period_nxt = period_r;
    delay_nxt  = delay_r;
    width_nxt  = width_r;
    tmo_nxt    = tmo_r;
    ortime_nxt = ortime_r;
    irq_en_nxt = irq_en_r;
    if (wr) begin
      unique case (paddr_in)
        OFF_CTRL:   ctrl_nxt   = pwdata_in[CTRL_W-1:0];
        OFF_PERIOD: period_nxt = pwdata_in;
        OFF_DELAY:  delay_nxt  = pwdata_in;
        OFF_WIDTH:  width_nxt  = pwdata_in;
        OFF_TMO:    tmo_nxt    = pwdata_in;
        OFF_ORTIME: ortime_nxt = pwdata_in[7:0];
        OFF_IRQ_EN: irq_en_nxt = pwdata_in[IRQ_W-1:0];
        default:    ;
      endcase
    end
  end

  // shared time base of 0.1 ms
  always_comb begin
    tick_nxt     = 1'b0;
    tick_cnt_nxt = tick_cnt_r + 32'h0000_0001;
    if (tick_cnt_r == 32'(TICK_CYCLES - 1)) begin
      tick_cnt_nxt = '0;
      tick_nxt     = 1'b1;
    end
  end

  proc_timer #(.W(TMR_W)) u_phase (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .load_in  (phase_load),
    .value_in (phase_val),
    .tick_in  (tick_r),
    .done_out (phase_done)
  );

  proc_timer #(.W(TMR_W)) u_period (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .load_in  (period_load),
    .value_in (period_r),
    .tick_in  (tick_r),
    .done_out (period_done)
  );

  proc_timer #(.W(TMR_W)) u_or (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .load_in  (or_load),
    .value_in (or_val),
    .tick_in  (tick_r),
    .done_out (or_done)
  );

  assign active = pend_r[RES_OVR_BIT] ^ pol_pass;
  assign or_val = TMR_W'(ortime_r) * TMR_W'(TICKS_PER_MS);

  always_comb begin
    state_nxt   = state_r;
    data_nxt    = data_r;
    strobe_nxt  = strobe_r;
    or_nxt      = or_r;
    pend_nxt    = pend_r;
    pend_v_nxt  = pend_v_r;
    phase_load  = 1'b0;
    phase_val   = delay_r;
    period_load = 1'b0;
    or_load     = 1'b0;
    ev          = '0;
    // one-shot ends when its timer runs out
    if (ctrl_r[CTRL_ONESHOT] && or_r && or_done) begin
      or_nxt = 1'b0;
    end
    unique case (state_r)
      ST_IDLE: begin
        if (pend_v_r) begin
          data_nxt    = pol_pass ? ~pend_r[RES_W-1:0] : pend_r[RES_W-1:0];
          pend_v_nxt  = 1'b0;
          phase_load  = 1'b1;
          period_load = 1'b1;
          if (ctrl_r[CTRL_ONESHOT]) begin
            or_nxt  = active && (ortime_r != 8'h00);
            or_load = 1'b1;
          end else begin
            or_nxt = active;
          end
          state_nxt = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (phase_done) begin
          strobe_nxt = 1'b1;
          phase_load = 1'b1;
          phase_val  = width_r;
          state_nxt  = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (phase_done) begin
          strobe_nxt     = 1'b0;
          ev[IRQ_SENT]   = 1'b1;
          if (ctrl_r[CTRL_HS]) begin
            phase_load = 1'b1;
            phase_val  = TMR_W'(tmo_r * TMR_W'(TICKS_PER_MS));
            state_nxt  = ST_ACK;
          end else begin
            state_nxt = ST_GAP;
          end
        end
      end
      ST_ACK: begin
        if (ack_in) begin
          ev[IRQ_ACK] = 1'b1;
          state_nxt   = ST_GAP;
        end else if (phase_done) begin
          ev[IRQ_TMO] = 1'b1;
          state_nxt   = ST_GAP;
        end
      end
      ST_GAP: begin
        if (period_done) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
    // newest result replaces one still waiting; a write beats the take
    if (wr && (paddr_in == OFF_RESULT)) begin
      pend_nxt   = pwdata_in[RES_W:0];
      pend_v_nxt = 1'b1;
    end
  end

  // sticky events, set wins over a clear in the same cycle
  always_comb begin
    irq_st_nxt = irq_st_r;
    if (wr && (paddr_in == OFF_IRQ_CLR)) begin
      irq_st_nxt = irq_st_r & ~pwdata_in[IRQ_W-1:0];
    end
    irq_st_nxt = irq_st_nxt | ev;
    irq_nxt    = |(irq_st_nxt & irq_en_nxt);
  end

  // processing phase reported by software drives the ready level
  always_comb begin
    ready_nxt = ready_r;
    if (wr && (paddr_in == OFF_PHASE)) begin
      if (pwdata_in[PH_START]) begin
        ready_nxt = 1'b0;
      end
      unique case (ctrl_r[CTRL_ENPT_LSB +: 2])
        ENPT_IMAGE: if (pwdata_in[PH_IMAGE]) ready_nxt = 1'b1;
        ENPT_MEAS:  if (pwdata_in[PH_MEAS])  ready_nxt = 1'b1;
        ENPT_DISP:  if (pwdata_in[PH_DISP])  ready_nxt = 1'b1;
        default:    if (pwdata_in[PH_MEAS])  ready_nxt = 1'b1;
      endcase
    end
    enable_nxt = ready_nxt ^ ctrl_nxt[CTRL_INV];
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      ctrl_r     <= CTRL_RST;
      period_r   <= PERIOD_RST;
      delay_r    <= DELAY_RST;
      width_r    <= WIDTH_RST;
      tmo_r      <= TMO_RST;
      ortime_r   <= ORTIME_RST;
      pend_r     <= '0;
      pend_v_r   <= 1'b0;
      irq_st_r   <= '0;
      irq_en_r   <= '0;
      prdata_r   <= '0;
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
      ready_r    <= 1'b1;
      enable_r   <= 1'b1;
      irq_r      <= 1'b0;
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
      state_r    <= ST_IDLE;
      data_r     <= '0;
      strobe_r   <= 1'b0;
      or_r       <= 1'b0;
    end else begin
      ctrl_r     <= ctrl_nxt;
      period_r   <= period_nxt;
      delay_r    <= delay_nxt;
      width_r    <= width_nxt;
      tmo_r      <= tmo_nxt;
      ortime_r   <= ortime_nxt;
      pend_r     <= pend_nxt;
      pend_v_r   <= pend_v_nxt;
      irq_st_r   <= irq_st_nxt;
      irq_en_r   <= irq_en_nxt;
      prdata_r   <= prdata_nxt;
      pready_r   <= pready_nxt;
      pslverr_r  <= pslverr_nxt;
      ready_r    <= ready_nxt;
      enable_r   <= enable_nxt;
      irq_r      <= irq_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      tick_r     <= tick_nxt;
      state_r    <= state_nxt;
      data_r     <= data_nxt;
      strobe_r   <= strobe_nxt;
      or_r       <= or_nxt;
    end
  end

  assign prdata_out            = prdata_r;
  assign pready_out            = pready_r;
  assign pslverr_out           = pslverr_r;
  assign result_data_lines_out = data_r;
  assign strobe_out            = strobe_r;
  assign fail_judgment_out     = or_r;
  assign enable_out            = enable_r;
  assign timeout_err_out       = irq_st_r[IRQ_TMO];
  assign irq_out               = irq_r;
endmodule

// ===== proc_top_assertions.sv
// checker of apb answer timing and result strobe sequencing at the proc_top ports
// assumes one clock domain and a synchronous active-low reset
module proc_top_assertions (
  input wire logic        clock_in,
  input wire logic        rst_n_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        ack_in,
  input wire logic [15:0] result_data_lines_out,
  input wire logic        strobe_out,
  input wire logic        timeout_err_out,
  input wire logic        enable_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);
  chk_pready_once: assert property (pready_out |=> !pready_out)
    else $error("pready longer than one cycle");
  chk_pready_wait: assert property (psel_in && !penable_in |=> !pready_out ##1 pready_out)
    else $error("pready not after one wait state");
  chk_unmapped_err: assert property (pready_out && (paddr_in > 8'h2C || paddr_in[1:0] != 2'h0)
    |-> pslverr_out && prdata_out == 32'h0000_0000)
    else $error("unmapped access not refused");
  chk_rdata_idle: assert property (!pready_out |-> prdata_out == 32'h0000_0000 && !pslverr_out)
    else $error("read data or error outside answer");
  // minimum legal delay and width are ten ticks, far above eight cycles
  chk_data_settle: assert property ($changed(result_data_lines_out) |-> !strobe_out [*8])
    else $error("strobe too soon after data change");
  chk_data_hold: assert property (strobe_out |-> $stable(result_data_lines_out))
    else $error("data moved under strobe");
  chk_strobe_width: assert property ($rose(strobe_out) |-> strobe_out [*8])
    else $error("strobe too short");
  chk_tmo_no_ack: assert property ($rose(timeout_err_out) |-> !$past(ack_in) && !strobe_out)
    else $error("timeout despite answer");
  chk_enable_reset: assert property ($rose(rst_n_in) |-> enable_out)
    else $error("enable low after reset");
endmodule

bind proc_top proc_top_assertions proc_top_assertions_inst (
  .clock_in, .rst_n_in, .psel_in, .penable_in, .paddr_in, .prdata_out, .pready_out,
  .pslverr_out, .ack_in, .result_data_lines_out, .strobe_out, .timeout_err_out, .enable_out
);

// ===== proc_rx_model.sv
// receiver model: captures result lines under the strobe, answers after it falls
// assumes strobe and data come from proc_top on the same clock
module proc_rx_model #(
  parameter int ACK_DLY = 3
) (
  input  wire logic        clock_in,
  input  wire logic        strobe_in,
  input  wire logic [15:0] data_in,
  input  wire logic        ack_en_in,
  output logic             ack_out = 1'b0,
  output logic [15:0]      cap_out = 16'h0000
);
  logic       strobe_d_r = 1'b0;
  logic [7:0] cnt_r      = 8'h00;
  // answer comes late on purpose so the block really has to wait
  always @(posedge clock_in) begin
    strobe_d_r <= strobe_in;
    if (strobe_in) begin
      cap_out <= data_in;
    end
    if (strobe_d_r && !strobe_in && ack_en_in) begin
      cnt_r <= 8'(ACK_DLY + 2);
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
    ack_out <= cnt_r inside {8'h01, 8'h02};
  end
endmodule

// ===== proc_top_tb.sv
// self-checking bench: apb register access and result output sequences of proc_top
// assumes proc_pkg, proc_top, proc_rx_model and the bound checker compiled first
module proc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import proc_pkg::*;
  localparam int TICK = 10;
  logic        clock_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        psel     = 1'b0;
  logic        pen      = 1'b0;
  logic        pwr      = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0000_0000;
  logic        ack_en   = 1'b1;
  logic [31:0] prdata;
  logic        pready, pslverr, ack, stb, fj, en, tmo, irq, err;
  logic [15:0] dat, cap;
  int          n_mismatch      = 0;
  int          samples_checked = 0;
  logic [7:0]  ra [7] = '{OFF_CTRL, OFF_PERIOD, OFF_DELAY, OFF_WIDTH, OFF_TMO, OFF_ORTIME,
                          OFF_IRQ_EN};
  logic [31:0] rv [7] = '{32'h0000_0008, 32'h0000_0064, 32'h0000_000A, 32'h0000_0032,
                          32'h0000_2710, 32'h0000_0000, 32'h0000_0000};

  proc_top #(.TICK_CYCLES(TICK)) proc_top_inst (
    .clock_in, .rst_n_in, .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .ack_in(ack), .result_data_lines_out(dat), .strobe_out(stb), .fail_judgment_out(fj),
    .enable_out(en), .timeout_err_out(tmo), .irq_out(irq)
  );
  proc_rx_model proc_rx_model_inst (
    .clock_in, .strobe_in(stb), .data_in(dat), .ack_en_in(ack_en), .ack_out(ack), .cap_out(cap)
  );

  task automatic close_out();
    $display("mismatches %0d of %0d checks", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rng(input int n, input int lo, input int hi);
    chk(32'(n >= lo && n <= hi), 32'h0000_0001);
  endtask

  // request held until pready is sampled high, released only after that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int i;
    @(posedge clock_in);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock_in);
    pen <= 1'b1;
    i = 0;
    do begin
      @(posedge clock_in);
      i++;
    end while (pready !== 1'b1 && i < 50);
    q   = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    // judge by the answer itself, so a late but valid answer is not a timeout
    if (pready !== 1'b1) begin
      n_mismatch++;
      close_out();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  task automatic wait_sig(ref logic s, input logic v, output int n);
    n = 0;
    while (s !== v) begin
      @(posedge clock_in);
      n++;
      if (n > 6000) begin
        n_mismatch++;
        close_out();
      end
    end
  endtask

  initial begin
    forever #5 clock_in = ~clock_in;
  end

  initial begin
    logic [31:0] q;
    int          n;
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'b1;
    for (int k = 0; k < 7; k++) begin
      apb(1'b0, ra[k], 32'h0000_0000, q);
      chk(q, rv[k]);
    end
    apb(1'b0, 8'h30, 32'h0000_0000, q);
    chk({q[30:0], err}, 32'h0000_0001);
    // shortest legal delay and width keep the run brief
    wr(OFF_PERIOD, 32'h0000_0028);
    wr(OFF_WIDTH, 32'h0000_000A);
    wr(OFF_IRQ_EN, 32'h0000_0001);
    wr(OFF_RESULT, 32'h0001_00A5);
    wr(OFF_RESULT, 32'h0000_5A00);
    wait_sig(stb, 1'b1, n);
    rng(n, 80, 105);
    chk({15'h0000, fj, dat}, 32'h0001_00A5);
    wait_sig(stb, 1'b0, n);
    rng(n, 88, 104);
    chk({16'h0000, cap}, 32'h0000_00A5);
    wait_sig(stb, 1'b1, n);
    rng(n, 270, 320);
    chk({15'h0000, fj, dat}, 32'h0000_5A00);
    chk(32'(irq), 32'h0000_0001);
    wr(OFF_IRQ_CLR, 32'h0000_0007);
    wr(OFF_IRQ_EN, 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
    wait_sig(stb, 1'b0, n);
    repeat (3) @(posedge clock_in);
    chk(32'(irq), 32'h0000_0000);
    apb(1'b0, OFF_IRQ_ST, 32'h0000_0000, q);
    chk(q, 32'h0000_0001);
    wr(OFF_CTRL, 32'h0000_000D);
    wr(OFF_ORTIME, 32'h0000_0002);
    wr(OFF_RESULT, 32'h0000_00A5);
    wait_sig(fj, 1'b1, n);
    chk(32'(dat), 32'h0000_FF5A);
    wait_sig(fj, 1'b0, n);
    rng(n, 180, 205);
    wr(OFF_CTRL, 32'h0000_000A);
    wr(OFF_TMO, 32'h0000_0001);
    wr(OFF_IRQ_CLR, 32'h0000_0007);
    wr(OFF_RESULT, 32'h0000_0001);
    wait_sig(stb, 1'b1, n);
    wait_sig(stb, 1'b0, n);
    repeat (20) @(posedge clock_in);
    apb(1'b0, OFF_IRQ_ST, 32'h0000_0000, q);
    chk({q[31:1], tmo}, 32'h0000_0004);
    ack_en <= 1'b0;
    wr(OFF_IRQ_CLR, 32'h0000_0007);
    wr(OFF_RESULT, 32'h0000_0002);
    wait_sig(stb, 1'b1, n);
    wr(OFF_RESULT, 32'h0000_0003);
    wait_sig(tmo, 1'b1, n);
    rng(n, 175, 215);
    chk(32'(dat), 32'h0000_0002);
    // gap state, ready level high, newer result still parked in the slot
    apb(1'b0, OFF_STATUS, 32'h0000_0000, q);
    chk(q, 32'h0000_0190);
    apb(1'b0, OFF_IRQ_ST, 32'h0000_0000, q);
    chk(q, 32'h0000_0003);
    wr(OFF_IRQ_EN, 32'h0000_0002);
    repeat (2) @(posedge clock_in);
    chk(32'(irq), 32'h0000_0001);
    wr(OFF_IRQ_CLR, 32'h0000_0002);
    repeat (2) @(posedge clock_in);
    chk({30'h0000_0000, tmo, irq}, 32'h0000_0000);
    // code 3 is unused and must act as the measurement point
    for (int c = 0; c < 4; c++) begin
      wr(OFF_CTRL, 32'(c << 3));
      wr(OFF_PHASE, 32'h0000_0001);
      @(posedge clock_in);
      chk(32'(en), 32'h0000_0000);
      for (int p = 1; p < 4; p++) begin
        wr(OFF_PHASE, 32'(1 << p));
        @(posedge clock_in);
        chk(32'(en), 32'(p > ((c == 3) ? 1 : c)));
      end
    end
    wr(OFF_CTRL, 32'h0000_0028);
    wr(OFF_PHASE, 32'h0000_0001);
    @(posedge clock_in);
    chk(32'(en), 32'h0000_0001);
    wr(OFF_PHASE, 32'h0000_0004);
    @(posedge clock_in);
    chk(32'(en), 32'h0000_0000);
    close_out();
  end
endmodule
